// File: rtl/nfot_consts.vh
// Command codes, op codes and timing constants for the NAND operation sequencer
`ifndef NFOT_CONSTS_VH
`define NFOT_CONSTS_VH

// ----------------------------------------
// Clock and conversions
// ----------------------------------------
`define NFOT_CLK_MHZ          25
// Longest waits round down
`define NFOT_US2CYC(u)        ((u)*`NFOT_CLK_MHZ)
`define NFOT_MS2CYC(m)        ((m)*1000*`NFOT_CLK_MHZ)
// Least waits round up
`define NFOT_NS2CYC_MIN(n)    (((n)*`NFOT_CLK_MHZ+999)/1000)

// ----------------------------------------
// Command bytes
// ----------------------------------------
`define NFOT_CMD_READ1        8'h00
`define NFOT_CMD_READ2        8'h30
`define NFOT_CMD_CREAD        8'h31
`define NFOT_CMD_CREAD_LAST   8'h3F
`define NFOT_CMD_COPY2        8'h3A
`define NFOT_CMD_PROG1        8'h80
`define NFOT_CMD_PROG1_MULTI  8'h81
`define NFOT_CMD_PROG_FINAL   8'h10
`define NFOT_CMD_PROG_MID     8'h11
`define NFOT_CMD_PROG_CACHE   8'h15
`define NFOT_CMD_ERASE1       8'h60
`define NFOT_CMD_ERASE2       8'hD0
`define NFOT_CMD_STATUS       8'h70
`define NFOT_CMD_RESET        8'hFF
`define NFOT_STATUS_READY_BIT 6

// ----------------------------------------
// Operation codes on the user port
// ----------------------------------------
`define NFOT_OP_RESET         3'h0
`define NFOT_OP_READ          3'h1
`define NFOT_OP_CREAD         3'h2
`define NFOT_OP_COPY_READ     3'h3
`define NFOT_OP_PROG_FINAL    3'h4
`define NFOT_OP_PROG_CACHE    3'h5
`define NFOT_OP_PROG_MID      3'h6
`define NFOT_OP_ERASE         3'h7

// ----------------------------------------
// Device times
// ----------------------------------------
`define NFOT_T_RST_READY_US   5
`define NFOT_T_RST_READ_US    5
`define NFOT_T_RST_PROG_US    10
`define NFOT_T_RST_ERASE_US   500
`define NFOT_T_W1_US          10
`define NFOT_T_W2_US          700
`define NFOT_T_ARRAY_US       25
`define NFOT_T_RCACHE_US      25
`define NFOT_T_COPY_US        30
`define NFOT_T_PROG_US        700
`define NFOT_T_ERASE_MS       5
`define NFOT_T_WB_NS          100
`define NFOT_T_WHR_NS         60
`define NFOT_PARTIAL_MAX      4

`endif

// File: rtl/nfot_fifo.v
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module nfot_fifo #(
	parameter W  = 8,
	parameter D  = 8,
	parameter AW = 3
) (
	input  wire         clock,
	input  wire         rst,
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data
);
	reg  [W-1:0] mem [0:D-1];
	reg  [AW-1:0] wr_ptr;
	reg  [AW-1:0] rd_ptr;
	reg  [AW:0]   fill;
	wire          push;
	wire          pop;

	// Honest full and empty from the fill count
	assign in_ready  = (fill != D[AW:0]);
	assign out_valid = (fill != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Pointers wrap at the depth
	always @(posedge clock) begin
		if (rst) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			fill   <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			end
			fill <= fill + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end

	// Storage write
	always @(posedge clock) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule
`default_nettype wire

// File: rtl/nfot_host.v
// Host sequencer driving an asynchronous 8-bit NAND flash through its pins
// What this block does
// - At most four successive partial programs on one page, until any erase
// - After 80h-15h end poll status, then FFh
// - Multi-page cache series ends 81h then 10h
// - After 81h-15h end poll status, then FFh
// - Command latched on write rise, CLE high
`timescale 1ns/1ns
`default_nettype none
`include "nfot_consts.vh"
module nfot_host #(
	parameter [16:0] PROG_CYC      = `NFOT_US2CYC(`NFOT_T_PROG_US),
	parameter [16:0] W2_CYC        = `NFOT_US2CYC(`NFOT_T_W2_US),
	parameter [16:0] ERASE_CYC     = `NFOT_MS2CYC(`NFOT_T_ERASE_MS),
	parameter [16:0] RST_ERASE_CYC = `NFOT_US2CYC(`NFOT_T_RST_ERASE_US),
	parameter        FIFO_DEPTH    = 8,
	parameter        FIFO_AW       = 3
) (
	input  wire        clock,
	input  wire        rst,
	input  wire        op_valid,
	output wire        op_ready,
	input  wire [2:0]  op_code,
	input  wire        op_multi,
	input  wire        op_last,
	input  wire [39:0] op_addr,
	input  wire [12:0] op_len,
	input  wire        wr_valid,
	output wire        wr_ready,
	input  wire [7:0]  wr_data,
	output reg  [7:0]  rd_data,
	output reg         rd_valid,
	output reg         done,
	output reg         err_timeout,
	output reg         err_partial,
	output reg         flash_ce_n,
	output reg         flash_cle,
	output reg         flash_ale,
	output reg         flash_we_n,
	output reg         read_strobe_n,
	output reg         flash_wp_n,
	output reg  [7:0]  flash_io_out,
	output reg         flash_io_oe,
	input  wire [7:0]  flash_io_in,
	input  wire        ready_busy_out
);
	// ----------------------------------------
	// Constants and states
	// ----------------------------------------
	localparam [16:0] TR_CYC    = `NFOT_US2CYC(`NFOT_T_ARRAY_US);
	localparam [16:0] R1_CYC    = `NFOT_US2CYC(`NFOT_T_RCACHE_US);
	localparam [16:0] R2_CYC    = `NFOT_US2CYC(`NFOT_T_COPY_US);
	localparam [16:0] W1_CYC    = `NFOT_US2CYC(`NFOT_T_W1_US);
	localparam [16:0] RST5_CYC  = `NFOT_US2CYC(`NFOT_T_RST_READY_US);
	localparam [16:0] RSTR_CYC  = `NFOT_US2CYC(`NFOT_T_RST_READ_US);
	localparam [16:0] RST10_CYC = `NFOT_US2CYC(`NFOT_T_RST_PROG_US);
	localparam [16:0] WB_CYC    = `NFOT_NS2CYC_MIN(`NFOT_T_WB_NS);
	localparam [16:0] WHR_CYC   = `NFOT_NS2CYC_MIN(`NFOT_T_WHR_NS);
	localparam [2:0]  PMAX      = `NFOT_PARTIAL_MAX;
	localparam [3:0] S_IDLE = 4'h0, S_CMD1 = 4'h1, S_ADDR = 4'h2, S_DATA = 4'h3;
	localparam [3:0] S_CMD2 = 4'h4, S_WB = 4'h5, S_BUSY = 4'h6, S_WHR = 4'h7;
	localparam [3:0] S_READ = 4'h8, S_PCMD = 4'h9, S_PWAIT = 4'hA, S_PRD = 4'hB;
	localparam [3:0] S_DONE = 4'hC;
	localparam [1:0] K_OTHER = 2'h0, K_PROG = 2'h1, K_ERASE = 2'h2;

	// Program operations share the data path
	function is_prog;
		input [2:0] op;
		begin
			is_prog = (op == `NFOT_OP_PROG_FINAL) || (op == `NFOT_OP_PROG_CACHE) || (op == `NFOT_OP_PROG_MID);
		end
	endfunction

	reg  [3:0]  state;
	reg  [1:0]  ph;
	reg  [16:0] cnt;
	reg  [12:0] idx;
	reg  [2:0]  op_q;
	reg         multi_q;
	reg         last_q;
	reg  [39:0] addr_q;
	reg  [12:0] len_q;
	reg         drain;
	reg         series_open;
	reg  [1:0]  last_kind;
	reg  [23:0] last_row;
	reg  [2:0]  pcount;
	reg         rb_s1;
	reg         rb_s2;
	reg         rb_s3;
	reg         rb;
	reg         ready_at_op;
	reg  [2:0]  jop;
	reg  [7:0]  d_c1;
	reg  [7:0]  d_c2;
	reg         d_addr;
	reg  [2:0]  d_astart;
	reg         d_c2_en;
	reg         d_read;
	reg  [16:0] d_tmo;
	reg  [7:0]  byte_out;
	wire        wr_state;
	wire        rd_state;
	wire        stall;
	wire        fifo_valid;
	wire [7:0]  fifo_data;
	wire        fifo_pop;

	// ----------------------------------------
	// Write data buffer
	// ----------------------------------------
	nfot_fifo #(.W(8), .D(FIFO_DEPTH), .AW(FIFO_AW)) u_wbuf (
		.clock     (clock),
		.rst       (rst),
		.in_valid  (wr_valid),
		.in_ready  (wr_ready),
		.in_data   (wr_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_data)
	);

	assign op_ready = (state == S_IDLE);
	assign wr_state = (state == S_CMD1) || (state == S_ADDR) || (state == S_DATA) || (state == S_CMD2) || (state == S_PCMD);
	assign rd_state = (state == S_READ) || (state == S_PRD);
	assign stall    = (state == S_DATA) && (ph == 2'h0) && !fifo_valid;
	assign fifo_pop = (state == S_DATA) && (ph == 2'h2);

	// ----------------------------------------
	// Ready/busy synchroniser
	// ----------------------------------------
	// Busy level filtered
	always @(posedge clock) begin
		if (rst) begin
			rb_s1 <= 1'b0;
			rb_s2 <= 1'b0;
			rb_s3 <= 1'b0;
			rb    <= 1'b0;
		end else begin
			rb_s1 <= ready_busy_out;
			rb_s2 <= rb_s1;
			rb_s3 <= rb_s2;
			if (rb_s2 == rb_s3) begin
				rb <= rb_s3;
			end
		end
	end

	// ----------------------------------------
	// Job decode
	// ----------------------------------------
	always @*
	begin
		jop      = drain ? `NFOT_OP_RESET : op_q;
		d_c1     = multi_q ? `NFOT_CMD_PROG1_MULTI : `NFOT_CMD_PROG1;
		d_c2     = `NFOT_CMD_PROG_FINAL;
		d_addr   = 1'b1;
		d_astart = 3'h0;
		d_c2_en  = 1'b1;
		d_read   = 1'b0;
		d_tmo    = PROG_CYC;
		case (jop)
			`NFOT_OP_RESET: begin
				d_c1    = `NFOT_CMD_RESET;
				d_addr  = 1'b0;
				d_c2_en = 1'b0;
				d_tmo   = ready_at_op ? RST5_CYC : (last_kind == K_ERASE) ? RST_ERASE_CYC :
					(last_kind == K_PROG) ? RST10_CYC : RSTR_CYC;
			end
			`NFOT_OP_READ: begin
				d_c1   = `NFOT_CMD_READ1;
				d_c2   = `NFOT_CMD_READ2;
				d_read = 1'b1;
				d_tmo  = TR_CYC;
			end
			`NFOT_OP_CREAD: begin
				d_c1    = last_q ? `NFOT_CMD_CREAD_LAST : `NFOT_CMD_CREAD;
				d_addr  = 1'b0;
				d_c2_en = 1'b0;
				d_read  = 1'b1;
				d_tmo   = R1_CYC;
			end
			`NFOT_OP_COPY_READ: begin
				d_c1   = `NFOT_CMD_READ1;
				d_c2   = `NFOT_CMD_COPY2;
				d_read = 1'b1;
				d_tmo  = R2_CYC;
			end
			`NFOT_OP_PROG_FINAL: begin
				d_tmo = PROG_CYC;
			end
			`NFOT_OP_PROG_CACHE: begin
				d_c2  = `NFOT_CMD_PROG_CACHE;
				d_tmo = W2_CYC;
			end
			`NFOT_OP_PROG_MID: begin
				d_c2  = `NFOT_CMD_PROG_MID;
				d_tmo = W1_CYC;
			end
			default: begin
				d_c1     = `NFOT_CMD_ERASE1;
				d_c2     = `NFOT_CMD_ERASE2;
				d_astart = 3'h2;
				d_tmo    = ERASE_CYC;
			end
		endcase
		case (state)
			S_CMD1:  byte_out = d_c1;
			S_ADDR:  byte_out = addr_q[{idx[2:0], 3'h0} +: 8];
			S_DATA:  byte_out = fifo_data;
			S_CMD2:  byte_out = d_c2;
			S_PCMD:  byte_out = `NFOT_CMD_STATUS;
			default: byte_out = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Pin drivers, registered
	// ----------------------------------------
	// Command byte with CLE high around write rise
	always @(posedge clock) begin
		if (rst) begin
			flash_ce_n    <= 1'b1;
			flash_cle     <= 1'b0;
			flash_ale     <= 1'b0;
			flash_we_n    <= 1'b1;
			read_strobe_n <= 1'b1;
			flash_wp_n    <= 1'b0;
			flash_io_out  <= 8'h00;
			flash_io_oe   <= 1'b0;
		end else begin
			flash_ce_n    <= (state == S_IDLE) || (state == S_DONE);
			flash_cle     <= (state == S_CMD1) || (state == S_CMD2) || (state == S_PCMD);
			flash_ale     <= (state == S_ADDR);
			flash_we_n    <= !(wr_state && (ph == 2'h1));
			// Equal one-cycle low and high intervals, sample while low
			read_strobe_n <= !(rd_state && (ph == 2'h0));
			flash_wp_n    <= 1'b1;
			flash_io_out  <= wr_state ? byte_out : 8'h00;
			flash_io_oe   <= wr_state;
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always @(posedge clock) begin
		if (rst) begin
			state       <= S_IDLE;
			ph          <= 2'h0;
			cnt         <= 17'h00000;
			idx         <= 13'h0000;
			op_q        <= `NFOT_OP_RESET;
			multi_q     <= 1'b0;
			last_q      <= 1'b0;
			addr_q      <= 40'h0000000000;
			len_q       <= 13'h0000;
			drain       <= 1'b0;
			series_open <= 1'b0;
			last_kind   <= K_OTHER;
			last_row    <= 24'h000000;
			pcount      <= 3'h0;
			ready_at_op <= 1'b0;
			rd_data     <= 8'h00;
			rd_valid    <= 1'b0;
			done        <= 1'b0;
			err_timeout <= 1'b0;
			err_partial <= 1'b0;
		end else begin
			rd_valid    <= 1'b0;
			done        <= (state == S_DONE);
			err_timeout <= 1'b0;
			err_partial <= 1'b0;
			// Strobe phase: three for writes, two for reads
			if (wr_state) begin
				ph <= (ph == 2'h2) ? 2'h0 : (stall ? ph : ph + 2'h1);
			end else if (rd_state) begin
				ph <= (ph == 2'h1) ? 2'h0 : 2'h1;
			end else begin
				ph <= 2'h0;
			end
			case (state)
				S_IDLE: begin
					cnt <= 17'h00000;
					idx <= 13'h0000;
					if (op_valid) begin
						op_q    <= op_code;
						multi_q <= op_multi;
						last_q  <= op_last;
						addr_q  <= op_addr;
						len_q   <= op_len;
						// Device state before our own command, for the reset bound
						ready_at_op <= rb;
						if (is_prog(op_code) && (op_addr[39:16] == last_row) && (pcount == PMAX)) begin
							err_partial <= 1'b1;
							state       <= S_DONE;
						end else begin
							if (is_prog(op_code)) begin
								last_row <= op_addr[39:16];
								pcount   <= (op_addr[39:16] == last_row) ? pcount + 3'h1 : 3'h1;
							end else if (op_code == `NFOT_OP_ERASE) begin
								pcount <= 3'h0;
							end
							// Open cache series is drained first
							state <= (series_open && !is_prog(op_code)) ? S_PCMD : S_CMD1;
						end
					end
				end
				S_CMD1: begin
					if (ph == 2'h2) begin
						idx   <= {10'h000, d_astart};
						state <= d_addr ? S_ADDR : (d_c2_en ? S_CMD2 : S_WB);
					end
				end
				S_ADDR: begin
					if (ph == 2'h2) begin
						idx <= 13'h0000;
						if (idx[2:0] != 3'h4) begin
							idx <= idx + 13'h0001;
						end else if (is_prog(jop) && (len_q != 13'h0000)) begin
							state <= S_DATA;
						end else begin
							state <= S_CMD2;
						end
					end
				end
				S_DATA: begin
					if (ph == 2'h2) begin
						idx <= idx + 13'h0001;
						if (idx == len_q - 13'h0001) begin
							state <= S_CMD2;
						end
					end
				end
				S_CMD2: begin
					if (ph == 2'h2) begin
						state     <= S_WB;
						last_kind <= is_prog(jop) ? K_PROG : (jop == `NFOT_OP_ERASE) ? K_ERASE : K_OTHER;
					end
				end
				S_WB: begin
					cnt <= cnt + 17'h00001;
					// Busy onset plus synchroniser depth, so a stale ready is never seen
					if (cnt == WB_CYC + 17'h00002) begin
						cnt   <= 17'h00000;
						state <= S_BUSY;
					end
				end
				// Wait for ready with bounded timeout
				S_BUSY: begin
					cnt <= cnt + 17'h00001;
					if (rb) begin
						cnt <= 17'h00000;
						idx <= 13'h0000;
						if (drain) begin
							drain       <= 1'b0;
							series_open <= 1'b0;
							state       <= S_CMD1;
						end else begin
							series_open <= (op_q == `NFOT_OP_PROG_CACHE);
							state       <= d_read ? S_WHR : S_DONE;
						end
					end else if (cnt == d_tmo) begin
						err_timeout <= 1'b1;
						drain       <= 1'b0;
						state       <= S_DONE;
					end
				end
				S_WHR, S_PWAIT: begin
					cnt <= cnt + 17'h00001;
					if (cnt == WHR_CYC - 17'h00001) begin
						cnt   <= 17'h00000;
						state <= (state == S_WHR) ? S_READ : S_PRD;
					end
				end
				S_READ: begin
					if (ph == 2'h1) begin
						rd_data  <= flash_io_in;
						rd_valid <= 1'b1;
						idx      <= idx + 13'h0001;
						if (idx == len_q - 13'h0001) begin
							state <= S_DONE;
						end
					end
				end
				S_PCMD: begin
					if (ph == 2'h2) begin
						state <= S_PWAIT;
					end
				end
				S_PRD: begin
					cnt <= cnt + 17'h00001;
					if ((ph == 2'h1) && flash_io_in[`NFOT_STATUS_READY_BIT]) begin
						cnt   <= 17'h00000;
						drain <= 1'b1;
						state <= S_CMD1;
					end else if (cnt >= W2_CYC) begin
						err_timeout <= 1'b1;
						state       <= S_DONE;
					end
				end
				S_DONE: begin
					state <= S_IDLE;
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// File: dv/nfot_host_properties.sv
// Port-level assertions for the NAND host sequencer
`timescale 1ns/1ns
`default_nettype none
`include "nfot_consts.vh"
module nfot_host_properties (
	input wire logic       clock,
	input wire logic       rst,
	input wire logic       done,
	input wire logic       err_partial,
	input wire logic       rd_valid,
	input wire logic       flash_ce_n,
	input wire logic       flash_cle,
	input wire logic       flash_ale,
	input wire logic       flash_we_n,
	input wire logic       read_strobe_n,
	input wire logic [7:0] flash_io_out,
	input wire logic       flash_io_oe,
	input wire logic       ready_busy_out
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// Write side strobes
	cmd_latch_a: assert property ($rose(flash_we_n) && flash_cle |-> flash_io_oe && !flash_ale && !flash_ce_n)
		else $error("command strobe without bus drive");
	write_pulse_a: assert property ($fell(flash_we_n) |=> flash_we_n && $stable(flash_io_out))
		else $error("write strobe too long or data moved");
	// Read side strobes
	bus_release_a: assert property (!read_strobe_n |-> !flash_io_oe)
		else $error("host drives bus during read strobe");
	strobe_cycle_a: assert property ($fell(read_strobe_n) |=> $rose(read_strobe_n))
		else $error("read strobe low longer than one cycle");
	byte_source_a: assert property (rd_valid |-> !$past(read_strobe_n) || !$past(read_strobe_n, 2)
		|| !$past(read_strobe_n, 3))
		else $error("read byte without a read strobe");
	// Busy handling
	busy_quiet_a: assert property (!ready_busy_out ##1 !ready_busy_out ##1 !ready_busy_out |-> read_strobe_n)
		else $error("read strobe while device busy");
	tail_wait_a: assert property ($rose(flash_we_n) && flash_cle && flash_io_out == `NFOT_CMD_READ2
		|=> read_strobe_n [*3])
		else $error("read strobe too soon after read confirm");
	// Completion
	partial_done_a: assert property (err_partial |-> flash_we_n ##1 done)
		else $error("refused program without completion");
	done_pulse_a: assert property (done |=> !done)
		else $error("done longer than one cycle");
endmodule
bind nfot_host nfot_host_properties u_props (.clock(clock), .rst(rst), .done(done), .err_partial(err_partial),
	.rd_valid(rd_valid), .flash_ce_n(flash_ce_n), .flash_cle(flash_cle), .flash_ale(flash_ale),
	.flash_we_n(flash_we_n), .read_strobe_n(read_strobe_n), .flash_io_out(flash_io_out),
	.flash_io_oe(flash_io_oe), .ready_busy_out(ready_busy_out));
`default_nettype wire

// File: dv/nfot_flash_model.sv
// Behavioural NAND device facing the host sequencer pins
`timescale 1ns/1ns
`default_nettype none
module nfot_flash_model (
	input  wire logic        clock,
	input  wire logic        flash_ce_n,
	input  wire logic        flash_cle,
	input  wire logic        flash_ale,
	input  wire logic        flash_we_n,
	input  wire logic        read_strobe_n,
	input  wire logic [7:0]  bus,
	input  wire logic [15:0] busy_len,
	output var  logic [7:0]  dout,
	output wire logic        drive,
	output wire logic        rb_low,
	output var  logic        proto_err
);
	logic [7:0]  mem [0:8191];
	logic [12:0] col;
	logic [23:0] row, last_row;
	logic [2:0]  acnt, pcnt;
	logic [15:0] busy_cnt;
	logic        stat, after_cache;
	// Page contents start as a known pattern
	initial begin
		for (int i = 0; i < 8192; i++)
			mem[i] = 8'(i) ^ 8'h5A;
		{col, row, last_row, acnt, pcnt, busy_cnt, stat, after_cache, proto_err, dout} = '0;
	end
	// outputs only while enabled and strobed
	assign drive = !flash_ce_n && !read_strobe_n;
	assign rb_low = busy_cnt != 16'h0000;
	// Busy countdown
	always @(posedge clock)
		if (busy_cnt != 16'h0000)
			busy_cnt <= busy_cnt - 16'h0001;
	// command on CLE, address on ALE, data otherwise
	always @(posedge flash_we_n) begin
		if (!flash_ce_n && flash_cle) begin
			stat = bus == 8'h70;
			if (after_cache && !(bus inside {8'h70, 8'hFF, 8'h80, 8'h81, 8'h10, 8'h11, 8'h15}))
				proto_err = 1'b1; // Cache end not closed by status poll and reset
			if (bus inside {8'h00, 8'h80, 8'h81})
				acnt = 3'h0;
			if (bus == 8'h60)
				acnt = 3'h2;
			if (bus inside {8'h31, 8'h3F})
				col = 13'h0000;
			if (bus == 8'hD0)
				pcnt = 3'h0;
			if (bus == 8'hFF)
				after_cache = 1'b0;
			if (bus inside {8'h10, 8'h11, 8'h15}) begin
				// programs on one row before erase
				pcnt = (row == last_row) ? pcnt + 3'h1 : 3'h1;
				proto_err = proto_err | (pcnt > 3'h4);
				last_row = row;
				after_cache = bus == 8'h15;
			end
			if (bus inside {8'h30, 8'h3A, 8'h31, 8'h3F, 8'h10, 8'h11, 8'h15, 8'hD0, 8'hFF})
				busy_cnt = busy_len;
		end else if (!flash_ce_n && flash_ale) begin
			case (acnt)
				3'h0: col[7:0] = bus;
				3'h1: col[12:8] = bus[4:0];
				3'h2: row[7:0] = bus;
				3'h3: row[15:8] = bus;
				default: row[23:16] = bus;
			endcase
			acnt = acnt + 3'h1;
		end else if (!flash_ce_n) begin
			mem[col] = bus;
			col = col + 13'h0001;
		end
	end
	// each strobe fall gives the next byte or the status
	always @(negedge read_strobe_n) begin
		if (stat)
			dout = rb_low ? 8'h00 : 8'h40;
		else begin
			dout = mem[col];
			col = col + 13'h0001;
		end
	end
endmodule
`default_nettype wire

// File: dv/nfot_host_test.sv
// Self-checking bench for the NAND host sequencer with a device model
`timescale 1ns/1ns
`default_nettype none
`include "nfot_consts.vh"
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
	$display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module nfot_host_test;
	logic        clock = 1'b0, rst = 1'b1, op_valid = 1'b0, op_multi = 1'b0, op_last = 1'b0, wr_valid = 1'b0;
	logic [2:0]  op_code = 3'h0;
	logic [39:0] op_addr = 40'h0, a;
	logic [12:0] op_len = 13'h0000;
	logic [7:0]  wr_data = 8'h00, e8;
	logic [15:0] busy_len = 16'h001E;
	logic [1:0]  seen = 2'b00, e2;
	logic [7:0]  shadow [0:8191];
	logic [7:0]  exp_rd [$];
	logic [1:0]  exp_done [$];
	int          bad_count = 0, check_count = 0;
	wire         op_ready, wr_ready, rd_valid, done, err_to, err_pa, ce_n, cle, ale, we_n, re_n, wp_n;
	wire         io_oe, rb_low, drive, proto_err;
	wire  [7:0]  rd_data, io_out, dout, bus;
	// Shared bus: host, device, or inverse of the last byte when floating
	assign bus = io_oe ? io_out : drive ? dout : ~dout;
	nfot_host #(.PROG_CYC(17'h00078), .W2_CYC(17'h00078), .ERASE_CYC(17'h000C8), .RST_ERASE_CYC(17'h00064)) DUT (
		.clock(clock), .rst(rst), .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
		.op_multi(op_multi), .op_last(op_last), .op_addr(op_addr), .op_len(op_len), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid), .done(done),
		.err_timeout(err_to), .err_partial(err_pa), .flash_ce_n(ce_n), .flash_cle(cle), .flash_ale(ale),
		.flash_we_n(we_n), .read_strobe_n(re_n), .flash_wp_n(wp_n), .flash_io_out(io_out),
		.flash_io_oe(io_oe), .flash_io_in(bus), .ready_busy_out(!rb_low));
	nfot_flash_model u_flash (.clock(clock), .flash_ce_n(ce_n), .flash_cle(cle), .flash_ale(ale),
		.flash_we_n(we_n), .read_strobe_n(re_n), .bus(bus), .busy_len(busy_len), .dout(dout),
		.drive(drive), .rb_low(rb_low), .proto_err(proto_err));
	// Clock
	initial forever #20 clock = ~clock;
	// Result watcher: oldest note against each byte and each completion
	always @(posedge clock) begin
		seen <= seen | {err_to, err_pa};
		if (rd_valid) begin
			e8 = exp_rd.size() != 0 ? exp_rd.pop_front() : 8'hXX;
			`CHECK(rd_data, e8)
		end
		if (done) begin
			e2 = exp_done.size() != 0 ? exp_done.pop_front() : 2'bXX;
			`CHECK(seen | {err_to, err_pa}, e2)
			seen <= 2'b00;
		end
	end
	// Verdict and end of run
	task automatic report_and_stop;
		if (bad_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Random address on a given row
	function automatic logic [39:0] at(input logic [23:0] r);
		return {r, 3'b000, 13'($urandom_range(3000))};
	endfunction
	// Request an operation and note what it should give back
	task automatic issue(input logic [2:0] c, input logic m, l, input logic [39:0] ad, input logic [12:0] n,
		input logic [1:0] e);
		int base;
		base = (c == `NFOT_OP_CREAD) ? 0 : ad[12:0];
		if (c inside {`NFOT_OP_READ, `NFOT_OP_CREAD, `NFOT_OP_COPY_READ})
			for (int k = 0; k < n; k++)
				exp_rd.push_back(shadow[13'(base + k)]);
		exp_done.push_back(e);
		@(posedge clock);
		op_valid <= 1'b1;
		op_code <= c;
		op_multi <= m;
		op_last <= l;
		op_addr <= ad;
		op_len <= n;
		do @(negedge clock); while (op_ready !== 1'b1);
		@(posedge clock);
		op_valid <= 1'b0;
	endtask
	// Push random bytes into the write buffer
	task automatic feed(input logic [12:0] c, n);
		logic [7:0] d;
		for (int k = 0; k < n; k++) begin
			d = 8'($urandom);
			shadow[13'(c + k)] = d;
			@(posedge clock);
			wr_valid <= 1'b1;
			wr_data <= d;
			do @(negedge clock); while (wr_ready !== 1'b1);
		end
		@(posedge clock);
		wr_valid <= 1'b0;
	endtask
	// Program with its data, none when the program is refused
	task automatic prog(input logic [2:0] c, input logic m, input logic [39:0] ad, input logic [12:0] n,
		input logic [1:0] e);
		fork
			if (e != 2'b01) feed(ad[12:0], n);
			issue(c, m, 1'b0, ad, n, e);
		join
	endtask
	// Wait for all noted completions
	task automatic drain;
		for (int k = 0; k < 4000 && exp_done.size() != 0; k++)
			@(posedge clock);
	endtask
	// Watchdog
	initial begin
		repeat (40000) @(posedge clock);
		bad_count++;
		report_and_stop();
	end
	// Main sequence
	initial begin
		for (int i = 0; i < 8192; i++)
			shadow[i] = 8'(i) ^ 8'h5A;
		void'($urandom(79739));
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		issue(`NFOT_OP_RESET, 1'b0, 1'b0, 40'h0, 13'h0000, 2'b00);
		// Buffer fills and refuses, then drains into a 12-byte program
		a = at(24'h000001);
		feed(a[12:0], 13'h0008);
		@(negedge clock);
		`CHECK(wr_ready, 1'b0)
		fork
			feed(13'(a[12:0] + 8), 13'h0004);
			// single page closed by 80h then 10h
			issue(`NFOT_OP_PROG_FINAL, 1'b0, 1'b0, a, 13'h000C, 2'b00);
		join
		issue(`NFOT_OP_READ, 1'b0, 1'b0, a, 13'h000C, 2'b00);
		prog(`NFOT_OP_PROG_MID, 1'b1, at(24'h000002), 13'h0004, 2'b00);
		prog(`NFOT_OP_PROG_FINAL, 1'b1, at(24'h000003), 13'h0004, 2'b00);
		// multi cache end, then a read forces status poll and reset
		prog(`NFOT_OP_PROG_CACHE, 1'b1, at(24'h000004), 13'h0005, 2'b00);
		issue(`NFOT_OP_READ, 1'b0, 1'b0, at(24'h000004), 13'h0003, 2'b00);
		// single cache end, then an erase
		prog(`NFOT_OP_PROG_CACHE, 1'b0, at(24'h000005), 13'h0005, 2'b00);
		issue(`NFOT_OP_ERASE, 1'b0, 1'b0, at(24'h000005), 13'h0000, 2'b00);
		// cache read with 31h and 3Fh
		for (int l = 0; l < 2; l++)
			issue(`NFOT_OP_CREAD, 1'b0, 1'(l), 40'h0, 13'h0006, 2'b00);
		issue(`NFOT_OP_COPY_READ, 1'b0, 1'b0, at(24'h000006), 13'h0006, 2'b00);
		// fifth program of one row refused until erase
		a = at(24'h000007);
		repeat (4) prog(`NFOT_OP_PROG_FINAL, 1'b0, a, 13'h0002, 2'b00);
		prog(`NFOT_OP_PROG_FINAL, 1'b0, a, 13'h0002, 2'b01);
		issue(`NFOT_OP_ERASE, 1'b0, 1'b0, a, 13'h0000, 2'b00);
		prog(`NFOT_OP_PROG_FINAL, 1'b0, a, 13'h0002, 2'b00);
		// slow device: program busy beyond bound
		drain();
		@(posedge clock);
		busy_len <= 16'h00C8;
		prog(`NFOT_OP_PROG_FINAL, 1'b0, at(24'h000008), 13'h0001, 2'b10);
		drain();
		@(posedge clock);
		busy_len <= 16'h001E;
		// reset while the program still runs
		issue(`NFOT_OP_RESET, 1'b0, 1'b0, 40'h0, 13'h0000, 2'b00);
		drain();
		`CHECK(proto_err, 1'b0)
		`CHECK(exp_rd.size(), 0)
		`CHECK(exp_done.size(), 0)
		`CHECK(wp_n, 1'b1)
		report_and_stop();
	end
endmodule
`default_nettype wire
